// file: rtl/cps_pkg.sv
package cps_pkg;

  localparam int CLK_NS = 40;

  // Core and tightly coupled memory frequencies of the two active settings.
  localparam int LP_FREQ_MHZ = 96;
  localparam int HP_FREQ_MHZ = 192;

  // Time from power-on of the core until its retained state is usable.
  localparam int RESTORE_NS = 200;
  localparam int RESTORE_CYC = (RESTORE_NS + CLK_NS - 1) / CLK_NS;

  // Time the central power controller needs to settle a rail.
  localparam int RAIL_SETTLE_NS = 1000;
  localparam int RAIL_SETTLE_CYC = (RAIL_SETTLE_NS + CLK_NS - 1) / CLK_NS;

  localparam int TICK_RELOAD = 1000;

  localparam logic [1:0] RAIL_RET = 2'h0;
  localparam logic [1:0] RAIL_LP = 2'h1;
  localparam logic [1:0] RAIL_HP = 2'h2;

  localparam logic [1:0] PS_OFF = 2'h0;
  localparam logic [1:0] PS_DEEP = 2'h1;
  localparam logic [1:0] PS_SLEEP = 2'h2;
  localparam logic [1:0] PS_ACTIVE = 2'h3;

  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_MASK = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam int CTRL_DEEP_BIT = 0;
  localparam int CTRL_SOE_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;

  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_PWRUP = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_HP_UP = 4'h3,
    ST_HP_DN = 4'h4,
    ST_SLEEP = 4'h5,
    ST_DS_WIC = 4'h6,
    ST_DS_RET = 4'h7,
    ST_DS_DOWN = 4'h8,
    ST_DEEP = 4'h9,
    ST_DS_UP = 4'ha,
    ST_RESTORE = 4'hb
  } cps_pu_state_type;

  typedef enum logic [1:0] {
    CS_RUN = 2'h0,
    CS_REQ = 2'h1,
    CS_SLEPT = 2'h2
  } cps_core_state_type;

endpackage

// file: rtl/cps_if.sv
`timescale 1ns/1ps
interface cps_if #(
  parameter int IRQ_N = 8
);
  logic sleepReq;
  logic sleepDeep;
  logic [IRQ_N-1:0] wakeMask;
  logic nvicEvent;
  logic dbgEvent;
  logic dbgAttached;
  logic railAck;
  logic busClkEn;
  logic freeClkEn;
  logic corePwrEn;
  logic retainEn;
  logic restoreStb;
  logic coreRun;
  logic wicAck;
  logic [IRQ_N-1:0] nvicIrq;
  logic railReq;
  logic [1:0] railTgt;

  modport pu (
    input sleepReq, sleepDeep, wakeMask, nvicEvent, dbgEvent, dbgAttached,
    input railAck,
    output busClkEn, freeClkEn, corePwrEn, retainEn, restoreStb, coreRun,
    output wicAck, nvicIrq, railReq, railTgt
  );

  modport core (
    output sleepReq, sleepDeep, wakeMask, nvicEvent, dbgEvent, dbgAttached,
    output railAck,
    input busClkEn, freeClkEn, corePwrEn, retainEn, restoreStb, coreRun,
    input wicAck, nvicIrq, railReq, railTgt
  );
endinterface

// file: rtl/cps_core_end.sv
`timescale 1ns/1ps
module cps_core_end
  import cps_pkg::*;
#(
  parameter int IRQ_N = 8,
  parameter int TICK_LOAD = TICK_RELOAD,
  parameter int SETTLE_CYC = RAIL_SETTLE_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  cps_if.core link,
  input wire logic wfiExec,
  input wire logic wfeExec,
  input wire logic isrReturn,
  input wire logic dbgAttachIn,
  input wire logic dbgEvtIn,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic coreAsleep,
  output logic tickIrq,
  output logic [1:0] railLevel
);

  cps_core_state_type coreState_r;
  logic [7:0] ctrl_r;
  logic [7:0] mask_r;
  logic [15:0] tickCnt_r;
  logic [15:0] settleCnt_r;
  logic deepSeen_r;
  logic trigger;

  assign trigger = wfiExec | wfeExec | (isrReturn & ctrl_r[CTRL_SOE_BIT]);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
    end
    else if (regWr)
    begin
      if (regAddr == REG_CTRL)
        ctrl_r <= regWrData;
      if (regAddr == REG_MASK)
        mask_r <= regWrData;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdData <= 8'h00;
    else if (regRd)
    begin
      case (regAddr)
        REG_CTRL: regRdData <= ctrl_r;
        REG_MASK: regRdData <= mask_r;
        REG_STAT: regRdData <= {5'h00, deepSeen_r, coreState_r};
        default: regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      coreState_r <= CS_RUN;
    else
    begin
      case (coreState_r)
        CS_RUN:
          if (trigger && link.coreRun)
            coreState_r <= CS_REQ;
        CS_REQ:
          if (!link.coreRun)
            coreState_r <= CS_SLEPT;
        CS_SLEPT:
          if (link.coreRun)
            coreState_r <= CS_RUN;
        default:
          coreState_r <= CS_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      deepSeen_r <= 1'b0;
    else if (link.wicAck)
      deepSeen_r <= 1'b1;
    else if (coreState_r == CS_REQ)
      deepSeen_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tickCnt_r <= 16'h0000;
      tickIrq <= 1'b0;
    end
    else
    begin
      tickIrq <= 1'b0;
      if (link.freeClkEn && link.corePwrEn)
      begin
        if (tickCnt_r == 16'(TICK_LOAD - 1))
        begin
          tickCnt_r <= 16'h0000;
          tickIrq <= 1'b1;
        end
        else
          tickCnt_r <= tickCnt_r + 16'h0001;
      end
    end
  end

  // Central power controller: a rail settles a fixed time after request.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      settleCnt_r <= 16'h0000;
      link.railAck <= 1'b0;
      railLevel <= RAIL_RET;
    end
    else
    begin
      link.railAck <= 1'b0;
      if (link.railReq && !link.railAck)
      begin
        if (settleCnt_r == 16'(SETTLE_CYC - 1))
        begin
          settleCnt_r <= 16'h0000;
          link.railAck <= 1'b1;
          railLevel <= link.railTgt;
        end
        else
          settleCnt_r <= settleCnt_r + 16'h0001;
      end
      else
        settleCnt_r <= 16'h0000;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.sleepReq <= 1'b0;
      link.sleepDeep <= 1'b0;
      link.wakeMask <= '0;
      link.nvicEvent <= 1'b0;
      link.dbgEvent <= 1'b0;
      link.dbgAttached <= 1'b0;
      coreAsleep <= 1'b0;
    end
    else
    begin
      link.sleepReq <= (coreState_r == CS_RUN) ? (trigger && link.coreRun)
                       : (coreState_r == CS_REQ) && link.coreRun;
      link.sleepDeep <= ctrl_r[CTRL_DEEP_BIT];
      link.wakeMask <= mask_r[IRQ_N-1:0];
      link.nvicEvent <= tickIrq;
      link.dbgEvent <= dbgEvtIn;
      link.dbgAttached <= dbgAttachIn;
      coreAsleep <= (coreState_r == CS_SLEPT);
    end
  end

endmodule // cps_core_end

// file: rtl/cps_power_unit.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// How it works
// - High performance raises only core and memory clock.
// - Software asks, hardware sequences the mode change.
// - High performance needs the buck supply.
// - Core sees no separate high performance mode.
// - Active runs bus and free clocks.
// - Core sets sleep depth before requesting.
// - Three instructions or events raise sleep request.
// - Irq, event, debug or reset wakes core.
// - Sleep gates clocks, keeps core powered.
// - Deep sleep removes power, retains flops.
// - Deep entry handshakes and records wake conditions.
// - Free clock gated asleep, restarts on irq.
// - Tick timer stops in deep sleep, and in sleep unless a debugger is attached.
// - Debugger keeps free clock running in sleep.
// - Deep entry retains state, lowers rails.
// - Wake raises rails, restores, then releases core.
// - States off, deep, sleep, active.
// - Peripheral irqs reach both interrupt controllers.
module cps_power_unit
  import cps_pkg::*;
#(
  parameter int IRQ_N = 8
)
(
  input wire logic clk,
  input wire logic rst,
  cps_if.pu link,
  input wire logic hpModeReq,
  input wire logic buckSel,
  input wire logic [IRQ_N-1:0] periphIrq,
  output logic coreTcmFreqHigh,
  output logic [1:0] powerState,
  output logic hpRefused
);

  cps_pu_state_type state_r;
  cps_pu_state_type state_nxt;
  logic [IRQ_N-1:0] wakeMask_r;
  logic [7:0] restCnt_r;
  logic wakePend_r;
  logic wakeAny;
  logic hpWanted;

  function automatic logic clocksRun(input cps_pu_state_type s);
    clocksRun = (s == ST_ACTIVE) || (s == ST_HP_UP) || (s == ST_HP_DN);
  endfunction

  function automatic logic inDeepEntry(input cps_pu_state_type s);
    inDeepEntry = (s == ST_DS_WIC) || (s == ST_DS_RET) || (s == ST_DS_DOWN);
  endfunction

  assign wakeAny = (|(periphIrq & wakeMask_r)) | link.nvicEvent
                   | link.dbgEvent;

  assign hpWanted = hpModeReq & buckSel;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:
        state_nxt = ST_PWRUP;
      ST_PWRUP:
        if (link.railAck)
          state_nxt = ST_ACTIVE;
      ST_ACTIVE:
        if (link.sleepReq)
          state_nxt = link.sleepDeep ? ST_DS_WIC : ST_SLEEP;
        else if (hpWanted && !coreTcmFreqHigh)
          state_nxt = ST_HP_UP;
        else if (!hpWanted && coreTcmFreqHigh)
          state_nxt = ST_HP_DN;
      ST_HP_UP:
        if (link.railAck)
          state_nxt = ST_ACTIVE;
      ST_HP_DN:
        if (link.railAck)
          state_nxt = ST_ACTIVE;
      ST_SLEEP:
        if (wakeAny)
          state_nxt = ST_ACTIVE;
      ST_DS_WIC:
        state_nxt = ST_DS_RET;
      ST_DS_RET:
        if (wakeAny || wakePend_r)
          state_nxt = ST_RESTORE;
        else
          state_nxt = ST_DS_DOWN;
      ST_DS_DOWN:
        if (link.railAck)
          state_nxt = (wakeAny || wakePend_r) ? ST_DS_UP : ST_DEEP;
      ST_DEEP:
        if (wakeAny || wakePend_r)
          state_nxt = ST_DS_UP;
      ST_DS_UP:
        if (link.railAck)
          state_nxt = ST_RESTORE;
      ST_RESTORE:
        if (restCnt_r == 8'(RESTORE_CYC - 1))
          state_nxt = ST_ACTIVE;
      default:
        state_nxt = ST_OFF;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= ST_OFF;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wakeMask_r <= '1;
    else if (state_r == ST_ACTIVE && link.sleepReq)
      wakeMask_r <= link.wakeMask;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wakePend_r <= 1'b0;
    else if (wakeAny && inDeepEntry(state_r))
      wakePend_r <= 1'b1;
    else if (state_nxt == ST_DS_UP || state_nxt == ST_RESTORE)
      wakePend_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      restCnt_r <= 8'h00;
    else if (state_r == ST_RESTORE)
      restCnt_r <= restCnt_r + 8'h01;
    else
      restCnt_r <= 8'h00;
  end

  // Only core and memory clock switch frequency.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      coreTcmFreqHigh <= 1'b0;
    else if (state_r == ST_HP_UP && link.railAck)
      coreTcmFreqHigh <= 1'b1;
    // Frequency drops before the rail is lowered, never after.
    else if (state_nxt == ST_HP_DN || state_nxt == ST_DS_WIC)
      coreTcmFreqHigh <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hpRefused <= 1'b0;
    else
      hpRefused <= hpModeReq & ~buckSel;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.busClkEn <= 1'b0;
      link.coreRun <= 1'b0;
      link.freeClkEn <= 1'b0;
    end
    else
    begin
      link.busClkEn <= clocksRun(state_nxt);
      link.coreRun <= clocksRun(state_nxt);
      link.freeClkEn <= clocksRun(state_nxt)
                        || (state_nxt == ST_SLEEP && link.dbgAttached);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.corePwrEn <= 1'b0;
      link.retainEn <= 1'b0;
      link.restoreStb <= 1'b0;
      link.wicAck <= 1'b0;
    end
    else
    begin
      link.corePwrEn <= !(state_nxt == ST_OFF || state_nxt == ST_PWRUP
                          || state_nxt == ST_DS_DOWN
                          || state_nxt == ST_DEEP || state_nxt == ST_DS_UP);
      link.retainEn <= (state_nxt == ST_DS_RET) || (state_nxt == ST_DS_DOWN)
                       || (state_nxt == ST_DEEP) || (state_nxt == ST_DS_UP)
                       || (state_nxt == ST_RESTORE);
      link.restoreStb <= (state_nxt == ST_RESTORE)
                         && (state_r != ST_RESTORE);
      link.wicAck <= (state_nxt == ST_DS_WIC);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      link.railReq <= 1'b0;
      link.railTgt <= RAIL_RET;
    end
    else
    begin
      link.railReq <= (state_nxt == ST_PWRUP) || (state_nxt == ST_HP_UP)
                      || (state_nxt == ST_HP_DN) || (state_nxt == ST_DS_DOWN)
                      || (state_nxt == ST_DS_UP);
      case (state_nxt)
        ST_HP_UP: link.railTgt <= RAIL_HP;
        ST_DS_DOWN: link.railTgt <= RAIL_RET;
        ST_PWRUP, ST_HP_DN, ST_DS_UP: link.railTgt <= RAIL_LP;
        default: link.railTgt <= link.railTgt;
      endcase
    end
  end

  // Irqs forwarded to core as well.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      link.nvicIrq <= '0;
    else
      link.nvicIrq <= periphIrq;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      powerState <= PS_OFF;
    else
    begin
      case (state_nxt)
        ST_OFF, ST_PWRUP: powerState <= PS_OFF;
        ST_SLEEP: powerState <= PS_SLEEP;
        ST_DS_DOWN, ST_DEEP, ST_DS_UP: powerState <= PS_DEEP;
        default: powerState <= PS_ACTIVE;
      endcase
    end
  end

endmodule // cps_power_unit

// file: test/cps_monitor.sv
`timescale 1ns/1ps
module cps_monitor
  import cps_pkg::*;
#(
  parameter int IRQ_N = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sleepReq,
  input wire logic sleepDeep,
  input wire logic [IRQ_N-1:0] wakeMask,
  input wire logic nvicEvent,
  input wire logic dbgEvent,
  input wire logic dbgAttached,
  input wire logic railAck,
  input wire logic busClkEn,
  input wire logic freeClkEn,
  input wire logic corePwrEn,
  input wire logic retainEn,
  input wire logic restoreStb,
  input wire logic coreRun,
  input wire logic wicAck,
  input wire logic [IRQ_N-1:0] nvicIrq,
  input wire logic railReq,
  input wire logic [1:0] railTgt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RUN_CLOCKS: assert property (
    coreRun |-> busClkEn && freeClkEn && corePwrEn)
    else $error("core runs without clocks or power");
  AST_SLEEP_TAKEN: assert property (
    $rose(sleepReq) |-> ##[1:40] !busClkEn && corePwrEn)
    else $error("sleep request not answered by clock gating");
  AST_FREE_DBG: assert property (
    $fell(busClkEn) && !wicAck |-> freeClkEn == dbgAttached)
    else $error("free clock does not follow debugger in sleep");
  AST_WIC_DEEP: assert property (
    wicAck |-> $fell(busClkEn) && $past(sleepDeep))
    else $error("wake controller ack outside deep entry");
  AST_PWR_OFF_RET: assert property (
    $fell(corePwrEn) |-> retainEn && railReq && railTgt == RAIL_RET)
    else $error("power removed without retention and rail drop");
  AST_DEEP_STILL: assert property (
    !corePwrEn && retainEn |-> !busClkEn && !freeClkEn && !coreRun)
    else $error("clocks run while core power is off");
  AST_RESTORE_PWR: assert property (
    restoreStb |-> corePwrEn && !coreRun)
    else $error("restore strobe without power or with core running");
  AST_RELEASE: assert property (
    $fell(retainEn) |-> corePwrEn && coreRun && busClkEn)
    else $error("retention dropped without core release");
  AST_RAIL_ACK: assert property (
    $rose(railReq) |-> ##[1:40] railAck)
    else $error("rail request not acknowledged");
  // Restore may add the retention hold, hence the wide window.
  AST_WAKE_IRQ: assert property (
    (corePwrEn && !retainEn && !busClkEn && !railReq)
      ##1 (|(nvicIrq & wakeMask)) |-> ##[0:12] busClkEn && freeClkEn)
    else $error("enabled interrupt did not restart clocks");

  cover property (!busClkEn && corePwrEn && !sleepDeep);
  cover property (!corePwrEn && retainEn);
  cover property (railAck && railTgt == RAIL_HP);
endmodule // cps_monitor

// file: test/test_cpu_power_sequencer.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) begin \
  @(posedge clk); #1; end
module test_cpu_power_sequencer
  import cps_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hpModeReq, buckSel, wfiExec, wfeExec, isrReturn, dbgAttachIn;
  logic dbgEvtIn, regWr, regRd, coreTcmFreqHigh, hpRefused, coreAsleep;
  logic tickIrq;
  logic [7:0] periphIrq, regWrData, regRdData, rd;
  logic [1:0] regAddr, powerState, railLevel;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int ticks;

  always #20 clk = ~clk;

  cps_if cps_if_i ();
  cps_power_unit cps_power_unit_i (.clk(clk), .rst(rst),
    .link(cps_if_i), .hpModeReq(hpModeReq), .buckSel(buckSel),
    .periphIrq(periphIrq), .coreTcmFreqHigh(coreTcmFreqHigh),
    .powerState(powerState), .hpRefused(hpRefused));
  // Short tick and settle keep the run brief; figures below follow them.
  cps_core_end #(.IRQ_N(8), .TICK_LOAD(200), .SETTLE_CYC(2))
    cps_core_end_i (.clk(clk), .rst(rst), .link(cps_if_i),
    .wfiExec(wfiExec), .wfeExec(wfeExec), .isrReturn(isrReturn),
    .dbgAttachIn(dbgAttachIn), .dbgEvtIn(dbgEvtIn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .coreAsleep(coreAsleep), .tickIrq(tickIrq),
    .railLevel(railLevel));
  cps_monitor cps_monitor_i (.clk(clk), .rst(rst),
    .sleepReq(cps_if_i.sleepReq), .sleepDeep(cps_if_i.sleepDeep),
    .wakeMask(cps_if_i.wakeMask), .nvicEvent(cps_if_i.nvicEvent),
    .dbgEvent(cps_if_i.dbgEvent), .dbgAttached(cps_if_i.dbgAttached),
    .railAck(cps_if_i.railAck), .busClkEn(cps_if_i.busClkEn),
    .freeClkEn(cps_if_i.freeClkEn), .corePwrEn(cps_if_i.corePwrEn),
    .retainEn(cps_if_i.retainEn), .restoreStb(cps_if_i.restoreStb),
    .coreRun(cps_if_i.coreRun), .wicAck(cps_if_i.wicAck),
    .nvicIrq(cps_if_i.nvicIrq), .railReq(cps_if_i.railReq),
    .railTgt(cps_if_i.railTgt));

  task report_and_stop();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task trig(input int t);
    @(posedge clk);
    wfiExec <= (t == 0);
    wfeExec <= (t == 1);
    isrReturn <= (t == 2);
    @(posedge clk);
    {wfiExec, wfeExec, isrReturn} <= 3'h0;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    {hpModeReq, buckSel, wfiExec, wfeExec, isrReturn} = 5'h00;
    {dbgAttachIn, dbgEvtIn, regWr, regRd} = 4'h0;
    periphIrq = 8'h00;
    regWrData = 8'h00;
    regAddr = 2'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    `WAITC(powerState === PS_ACTIVE, 60)
    `CHK(powerState, PS_ACTIVE)
    `CHK(cps_if_i.freeClkEn, 1'b1)
    `CHK(railLevel, RAIL_LP)
    reg_rd(REG_MASK, rd);
    `CHK(rd, MASK_RST)
    reg_wr(REG_STAT, 8'h5a);
    reg_rd(REG_STAT, rd);
    `CHK(rd, 8'h00)
    reg_rd(2'h3, rd);
    `CHK(rd, 8'h00)
    reg_wr(REG_MASK, 8'h03);
    reg_rd(REG_MASK, rd);
    `CHK(rd, 8'h03)
    @(posedge clk);
    hpModeReq <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(hpRefused, 1'b1)
    `CHK(coreTcmFreqHigh, 1'b0)
    @(posedge clk);
    buckSel <= 1'b1;
    `WAITC(coreTcmFreqHigh === 1'b1, 20)
    `CHK(coreTcmFreqHigh, 1'b1)
    `CHK(railLevel, RAIL_HP)
    `CHK(powerState, PS_ACTIVE)
    `CHK(cps_if_i.coreRun, 1'b1)
    @(posedge clk);
    hpModeReq <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(coreTcmFreqHigh, 1'b0)
    `WAITC(railLevel === RAIL_LP, 20)
    `CHK(railLevel, RAIL_LP)
    for (int t = 0; t < 3; t++)
    begin
      reg_wr(REG_CTRL, (t == 2) ? 8'h02 : 8'h00);
      trig(t);
      `WAITC(powerState === PS_SLEEP, 10)
      repeat (4) @(posedge clk);
      #1;
      `CHK(powerState, PS_SLEEP)
      `CHK(coreAsleep, 1'b1)
      `CHK(cps_if_i.corePwrEn, 1'b1)
      @(posedge clk);
      dbgEvtIn <= 1'b1;
      @(posedge clk);
      dbgEvtIn <= 1'b0;
      `WAITC(powerState === PS_ACTIVE, 10)
      `CHK(powerState, PS_ACTIVE)
    end
    // Bit outside the wake mask must not wake; the long stay also proves the tick froze.
    trig(0);
    `WAITC(powerState === PS_SLEEP, 10)
    @(posedge clk);
    periphIrq <= 8'h80;
    ticks = 0;
    repeat (250)
    begin
      @(posedge clk);
      #1;
      if (tickIrq === 1'b1)
        ticks++;
    end
    `CHK(powerState, PS_SLEEP)
    `CHK(ticks, 0)
    `CHK(cps_if_i.freeClkEn, 1'b0)
    `CHK(cps_if_i.nvicIrq, 8'h80)
    @(posedge clk);
    periphIrq <= 8'h01;
    `WAITC(powerState === PS_ACTIVE, 10)
    `CHK(powerState, PS_ACTIVE)
    `CHK(cps_if_i.freeClkEn, 1'b1)
    @(posedge clk);
    periphIrq <= 8'h00;
    reg_wr(REG_CTRL, 8'h01);
    trig(0);
    `WAITC(powerState === PS_DEEP, 40)
    `CHK(powerState, PS_DEEP)
    `CHK(cps_if_i.corePwrEn, 1'b0)
    `CHK(cps_if_i.retainEn, 1'b1)
    // The rail only reaches retention level once the controller acks.
    `WAITC(railLevel === RAIL_RET, 10)
    `CHK(railLevel, RAIL_RET)
    @(posedge clk);
    periphIrq <= 8'h02;
    // Restore already reports active; wait for the core release itself.
    `WAITC(cps_if_i.coreRun === 1'b1, 60)
    `CHK(powerState, PS_ACTIVE)
    `CHK(railLevel, RAIL_LP)
    `CHK(cps_if_i.retainEn, 1'b0)
    @(posedge clk);
    periphIrq <= 8'h00;
    // Wake lands in ST_DS_WIC once, then in ST_DS_DOWN twice: at its start and at the rail ack.
    for (int d = 1; d < 6; d += 2)
    begin
      trig(0);
      repeat (d) @(posedge clk);
      periphIrq <= 8'h01;
      `WAITC(cps_if_i.coreRun === 1'b0, 5)
      `WAITC(cps_if_i.coreRun === 1'b1, 80)
      `CHK(powerState, PS_ACTIVE)
      `CHK(cps_if_i.corePwrEn, 1'b1)
      @(posedge clk);
      periphIrq <= 8'h00;
    end
    reg_wr(REG_CTRL, 8'h00);
    dbgAttachIn <= 1'b1;
    trig(0);
    `WAITC(powerState === PS_SLEEP, 10)
    `CHK(cps_if_i.freeClkEn, 1'b1)
    `WAITC(tickIrq === 1'b1, 260)
    `CHK(tickIrq, 1'b1)
    `WAITC(powerState === PS_ACTIVE, 10)
    `CHK(powerState, PS_ACTIVE)
    report_and_stop();
  end
endmodule // test_cpu_power_sequencer
